// file: acc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none

module acc_analog_model (
    input  wire logic                          clk,
    input  wire acc_pkg::acc_analog_cfg_t [1:0] cfg,
    input  wire logic [1:0][7:0]               plus_mv,
    input  wire logic [7:0]                    dac_mv,
    input  wire logic [7:0]                    fixed_mv,
    input  wire logic [3:0][7:0]               minus_mv,
    input  wire logic                          timer_run,
    output logic [1:0]                         raw,
    output logic                               timer_fall
);
    import acc_pkg::*;

    logic [2:0]      div_q;
    logic [1:0][7:0] vp;

    // input muxes of the core; a core that is off drives its output low
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            case (cfg[i].plus_input_sel)
                PSEL_PLUS_PIN: vp[i] = plus_mv[i];
                PSEL_DAC:      vp[i] = dac_mv;
                PSEL_FIXED:    vp[i] = fixed_mv;
                default:       vp[i] = 8'h00;
            endcase
            raw[i] = cfg[i].enable && (vp[i] > minus_mv[cfg[i].minus_input_sel]);
        end
    end

    // prescaled timer clock, still while stopped; one fall every 8 cycles
    always_ff @(posedge clk) begin
        div_q <= timer_run ? div_q + 3'h1 : 3'h0;
    end
    assign timer_fall = timer_run && (div_q == 3'h7);
endmodule

`default_nettype wire

// file: acc_pkg.sv
package acc_pkg;

    // register offsets on the plain register port (byte address, 8-bit data)
    localparam logic [3:0] ADDR_CTRL0_C1  = 4'h0;
    localparam logic [3:0] ADDR_CTRL0_C2  = 4'h1;
    localparam logic [3:0] ADDR_CTRL1_C1  = 4'h2;
    localparam logic [3:0] ADDR_CTRL1_C2  = 4'h3;
    localparam logic [3:0] ADDR_MIRROR    = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT  = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK  = 4'h6;

    // control register 0 field positions
    localparam int CTRL0_ON_BIT    = 7;
    localparam int CTRL0_RES_BIT   = 6;
    localparam int CTRL0_OE_BIT    = 5;
    localparam int CTRL0_POL_BIT   = 4;
    localparam int CTRL0_SP_BIT    = 2;
    localparam int CTRL0_HYS_BIT   = 1;
    localparam int CTRL0_SYNC_BIT  = 0;
    // control register 1 field positions
    localparam int CTRL1_RISE_BIT  = 7;
    localparam int CTRL1_FALL_BIT  = 6;
    localparam int CTRL1_PSEL_LSB  = 4;
    localparam int CTRL1_NSEL_LSB  = 0;

    // reset values
    localparam logic [7:0] CTRL0_RESET    = 8'h04;
    localparam logic [7:0] CTRL1_RESET    = 8'h00;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    // positive-input channel codes
    localparam logic [1:0] PSEL_PLUS_PIN = 2'h0;
    localparam logic [1:0] PSEL_DAC      = 2'h1;
    localparam logic [1:0] PSEL_FIXED    = 2'h2;
    localparam logic [1:0] PSEL_GROUND   = 2'h3;

    // settings of one comparator, as handed to the analog core
    typedef struct packed {
        logic       enable;
        logic       speed_power_sel;
        logic       hysteresis_on;
        logic [1:0] plus_input_sel;
        logic [1:0] minus_input_sel;
    } acc_analog_cfg_t;

endpackage

// file: acc_top.sv
// Functional notes
// RULE1 - control0 bit 7 switches the comparator on when set, off when clear
// RULE2 - control0 bit 6 reads 1 when plus exceeds minus, inverted by polarity
// RULE3 - control0 bit 4 inverts the comparator result before any use
// RULE4 - control0 bit 5 routes result to pin; pin drives only if direction bit clear
// RULE5 - control0 bit 2 selects fast mode when set, low power when clear; resets 1
// RULE6 - control0 bit 1 enables input hysteresis in the analog core
// RULE7 - control0 bit 0 updates timer and pin result only on timer clock fall
// RULE8 - control1 bit 7 sets the interrupt flag on each rising result edge
// RULE9 - control1 bit 6 sets the interrupt flag on each falling result edge
// RULE10 - control1 bits 5-4 pick plus input: pin, dac, fixed ref, ground
// RULE11 - control1 bits 1-0 pick one of four shared minus pins
// RULE12 - mirror register shows comparator 2 at bit 1, comparator 1 at bit 0
// RULE13 - unimplemented bits read zero: control0 bit 3, control1 bits 3-2
// RULE14 - every reset gives the same values; all zero but speed control
// RULE15 - software clears the flag; an edge during the clear keeps it set
// RULE16 - toggling polarity or enable can make an edge even when disabled
// RULE17 - the raw result is latched every cycle before reading or edge detection
// RULE18 - synchronous mode latches on the prescaled timer clock
// RULE19 - an edge is a change between this cycle's and last cycle's latched result
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module acc_top #(
    parameter int NUM_CMP = 2
) (
    input  wire logic                              clk,
    input  wire logic                              reset,
    input  wire logic [3:0]                        reg_addr,
    input  wire logic [7:0]                        reg_wdata,
    input  wire logic                              reg_write,
    input  wire logic                              reg_read,
    output logic [7:0]                             reg_rdata,
    input  wire logic [NUM_CMP-1:0]                analog_raw,
    input  wire logic                              timer_clk_fall,
    input  wire logic [NUM_CMP-1:0]                pin_direction_bit,
    output logic [NUM_CMP-1:0]                     pin_out,
    output logic [NUM_CMP-1:0]                     pin_oe,
    output logic [NUM_CMP-1:0]                     timer_result,
    output acc_pkg::acc_analog_cfg_t [NUM_CMP-1:0] analog_cfg,
    output logic                                   irq
);
    import acc_pkg::*;

    // raw comparator outputs are asynchronous to clk
    logic [NUM_CMP-1:0] raw_meta_q;
    logic [NUM_CMP-1:0] raw_sync_q;
    logic [NUM_CMP-1:0] tfall_meta_q;
    logic [NUM_CMP-1:0] tfall_sync_q;

    logic [7:0]         ctrl0_q [NUM_CMP];
    logic [7:0]         ctrl1_q [NUM_CMP];
    logic [NUM_CMP-1:0] cmp_result_q;
    logic [NUM_CMP-1:0] prev_result_q;
    logic [NUM_CMP-1:0] sync_hold_q;
    logic [NUM_CMP-1:0] cmp_irq_flag_q;
    logic [NUM_CMP-1:0] irq_mask_q;
    logic [7:0]         reg_rdata_q;

    logic [NUM_CMP-1:0] cmp_result_d;
    logic [NUM_CMP-1:0] edge_set;
    logic [NUM_CMP-1:0] flag_clear;
    logic [NUM_CMP-1:0] ext_result;
    logic [7:0]         read_mux;
    wire logic [NUM_CMP-1:0] analog_cfg_d_en;

    // control register 0 image: result bit live, bit 3 forced zero
    function automatic logic [7:0] ctrl0_view(input logic [7:0] c, input logic r);
        logic [7:0] v;
        v = c;
        v[CTRL0_RES_BIT] = r;                             // see RULE2
        v[3] = 1'b0;                                      // see RULE13
        return v;
    endfunction

    // synchroniser: first stage only feeds the second
    always_ff @(posedge clk) begin
        raw_meta_q <= analog_raw;
        raw_sync_q <= raw_meta_q;
    end

    // timer clock falling strobe arrives from another domain; one pair per comparator
    always_ff @(posedge clk) begin
        tfall_meta_q <= {NUM_CMP{timer_clk_fall}};
        tfall_sync_q <= tfall_meta_q;
    end

    // per comparator: polarity, edge detect, sync hold, outputs
    for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
        wire logic pol = ctrl0_q[i][CTRL0_POL_BIT];
        wire logic on  = ctrl0_q[i][CTRL0_ON_BIT];
        // a disabled core reads low, then polarity applies, so toggling
        // enable or polarity while off still produces an edge
        assign cmp_result_d[i] = (raw_sync_q[i] & on) ^ pol;          // see RULE3 see RULE16
        wire logic rise = cmp_result_q[i] & ~prev_result_q[i];        // see RULE19
        wire logic fall = ~cmp_result_q[i] & prev_result_q[i];        // see RULE19
        assign edge_set[i] = (rise & ctrl1_q[i][CTRL1_RISE_BIT])      // see RULE8
                           | (fall & ctrl1_q[i][CTRL1_FALL_BIT]);     // see RULE9
        assign ext_result[i] = ctrl0_q[i][CTRL0_SYNC_BIT] ? sync_hold_q[i]
                                                         : cmp_result_q[i]; // see RULE7
        assign analog_cfg_d_en[i] = on;
    end

    // write decode for the clear-by-one status register
    assign flag_clear = (reg_write && reg_addr == ADDR_IRQ_STAT)
                      ? reg_wdata[NUM_CMP-1:0] : '0;

    // read mux; unmapped addresses read zero
    always_comb begin
        read_mux = 8'h00;
        unique case (reg_addr)
            ADDR_CTRL0_C1: read_mux = ctrl0_view(ctrl0_q[0], cmp_result_q[0]);
            ADDR_CTRL0_C2: read_mux = ctrl0_view(ctrl0_q[1], cmp_result_q[1]);
            ADDR_CTRL1_C1: read_mux = ctrl1_q[0] & 8'hf3;                  // see RULE13
            ADDR_CTRL1_C2: read_mux = ctrl1_q[1] & 8'hf3;                  // see RULE13
            ADDR_MIRROR:   read_mux = {6'h00, cmp_result_q[1], cmp_result_q[0]}; // see RULE12
            ADDR_IRQ_STAT: read_mux = {6'h00, cmp_irq_flag_q};
            ADDR_IRQ_MASK: read_mux = {6'h00, irq_mask_q};
            default:       read_mux = 8'h00;
        endcase
    end

    // control registers; one reset value for every kind of reset
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int k = 0; k < NUM_CMP; k++) begin
                ctrl0_q[k] <= CTRL0_RESET;                // see RULE5 see RULE14
                ctrl1_q[k] <= CTRL1_RESET;                // see RULE14
            end
            irq_mask_q <= IRQ_MASK_RESET;
        end else if (reg_write) begin
            for (int k = 0; k < NUM_CMP; k++) begin
                if (reg_addr == 4'(ADDR_CTRL0_C1 + k))
                    ctrl0_q[k] <= reg_wdata & 8'hb7;      // result and bit 3 not writable
                if (reg_addr == 4'(ADDR_CTRL1_C1 + k))
                    ctrl1_q[k] <= reg_wdata & 8'hf3;
            end
            if (reg_addr == ADDR_IRQ_MASK)
                irq_mask_q <= reg_wdata[NUM_CMP-1:0];
        end
    end

    // result latch every cycle, previous copy for edges
    always_ff @(posedge clk) begin
        if (reset) begin
            cmp_result_q  <= '0;
            prev_result_q <= '0;
        end else begin
            cmp_result_q  <= cmp_result_d;                // see RULE17
            prev_result_q <= cmp_result_q;                // see RULE19
        end
    end

    // sync hold captures on the prescaled timer clock falling strobe
    always_ff @(posedge clk) begin
        if (reset)
            sync_hold_q <= '0;
        else
            for (int k = 0; k < NUM_CMP; k++)
                if (tfall_sync_q[k])
                    sync_hold_q[k] <= cmp_result_q[k];   // see RULE7 see RULE18
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (reset)
            cmp_irq_flag_q <= '0;
        else
            cmp_irq_flag_q <= (cmp_irq_flag_q & ~flag_clear) | edge_set; // see RULE15
    end

    // registered outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata_q  <= 8'h00;
            pin_out      <= '0;
            pin_oe       <= '0;
            timer_result <= '0;
            irq          <= 1'b0;
            // core settings start from the control register reset images
            for (int k = 0; k < NUM_CMP; k++)
                analog_cfg[k] <= '{CTRL0_RESET[CTRL0_ON_BIT],
                                   CTRL0_RESET[CTRL0_SP_BIT],          // see RULE5
                                   CTRL0_RESET[CTRL0_HYS_BIT],
                                   CTRL1_RESET[CTRL1_PSEL_LSB +: 2],
                                   CTRL1_RESET[CTRL1_NSEL_LSB +: 2]};
        end else begin
            reg_rdata_q  <= reg_read ? read_mux : 8'h00;
            timer_result <= ext_result;
            for (int k = 0; k < NUM_CMP; k++) begin
                pin_out[k] <= ext_result[k];
                // drive the pin only when routed out and its direction bit is clear
                pin_oe[k]  <= ctrl0_q[k][CTRL0_OE_BIT] & ~pin_direction_bit[k]; // see RULE4
                analog_cfg[k].enable          <= analog_cfg_d_en[k];            // see RULE1
                analog_cfg[k].speed_power_sel <= ctrl0_q[k][CTRL0_SP_BIT];      // see RULE5
                analog_cfg[k].hysteresis_on   <= ctrl0_q[k][CTRL0_HYS_BIT];     // see RULE6
                analog_cfg[k].plus_input_sel  <= ctrl1_q[k][CTRL1_PSEL_LSB +: 2]; // see RULE10
                analog_cfg[k].minus_input_sel <= ctrl1_q[k][CTRL1_NSEL_LSB +: 2]; // see RULE11
            end
            // level interrupt while any unmasked flag is set
            irq <= |(((cmp_irq_flag_q & ~flag_clear) | edge_set) & irq_mask_q);
        end
    end

    assign reg_rdata = reg_rdata_q;

    // checks next to the logic
    chk_flag_on_rise: assert property (@(posedge clk) disable iff (reset) // see RULE8
        (cmp_result_q[0] && !prev_result_q[0] && ctrl1_q[0][CTRL1_RISE_BIT])
        |=> cmp_irq_flag_q[0])
        else $error("rise edge did not set flag");
    chk_flag_on_fall: assert property (@(posedge clk) disable iff (reset) // see RULE9
        (!cmp_result_q[0] && prev_result_q[0] && ctrl1_q[0][CTRL1_FALL_BIT])
        |=> cmp_irq_flag_q[0])
        else $error("fall edge did not set flag");
    chk_set_beats_clear: assert property (@(posedge clk) disable iff (reset) // see RULE15
        (edge_set[1] && flag_clear[1]) |=> cmp_irq_flag_q[1])
        else $error("clear beat a new edge");
    chk_result_latch: assert property (@(posedge clk) disable iff (reset) // see RULE17
        cmp_result_q[0] == $past(cmp_result_d[0]))
        else $error("result not latched each cycle");
    chk_edge_compare: assert property (@(posedge clk) disable iff (reset) // see RULE19
        prev_result_q[1] == $past(cmp_result_q[1]))
        else $error("previous result wrong");
    chk_pin_enable: assert property (@(posedge clk) disable iff (reset) // see RULE4
        ##1 pin_oe[0] == $past(ctrl0_q[0][CTRL0_OE_BIT] & ~pin_direction_bit[0]))
        else $error("pin enable wrong");
    chk_sync_hold: assert property (@(posedge clk) disable iff (reset) // see RULE7
        (ctrl0_q[0][CTRL0_SYNC_BIT] && !tfall_sync_q[0] && $stable(ctrl0_q[0]))
        |=> $stable(sync_hold_q[0]))
        else $error("sync result moved off the timer fall");
    chk_mirror_read: assert property (@(posedge clk) disable iff (reset) // see RULE12
        (reg_read && reg_addr == ADDR_MIRROR)
        |=> reg_rdata[7:2] == 6'h00 && reg_rdata[1:0] == $past(cmp_result_q[1:0]))
        else $error("mirror read wrong");
    chk_polarity_edge: assert property (@(posedge clk) disable iff (reset) // see RULE16
        (!ctrl0_q[0][CTRL0_ON_BIT] && $changed(ctrl0_q[0][CTRL0_POL_BIT]))
        |=> cmp_result_q[0] == ctrl0_q[0][CTRL0_POL_BIT])
        else $error("polarity toggle gave no edge");
    // the live result bit must be the latched one, never a raw sample
    chk_ctrl0_read: assert property (@(posedge clk) disable iff (reset) // see RULE2
        (reg_read && reg_addr == ADDR_CTRL0_C1)
        |=> reg_rdata[CTRL0_RES_BIT] == $past(cmp_result_q[0]) && reg_rdata[3] == 1'b0)
        else $error("control0 read wrong");
    chk_ctrl1_zero: assert property (@(posedge clk) disable iff (reset) // see RULE13
        (reg_read && (reg_addr == ADDR_CTRL1_C1 || reg_addr == ADDR_CTRL1_C2))
        |=> reg_rdata[3:2] == 2'h0)
        else $error("control1 unused bits not zero");
    chk_cfg_enable: assert property (@(posedge clk) disable iff (reset) // see RULE1
        ##1 analog_cfg[0].enable == $past(ctrl0_q[0][CTRL0_ON_BIT]))
        else $error("core enable does not follow control");
    chk_cfg_speed: assert property (@(posedge clk) disable iff (reset) // see RULE5
        ##1 analog_cfg[1].speed_power_sel == $past(ctrl0_q[1][CTRL0_SP_BIT]))
        else $error("speed select does not follow control");
    chk_plus_select: assert property (@(posedge clk) disable iff (reset) // see RULE10
        ##1 analog_cfg[0].plus_input_sel == $past(ctrl1_q[0][CTRL1_PSEL_LSB +: 2]))
        else $error("plus input select wrong");
    chk_async_path: assert property (@(posedge clk) disable iff (reset) // see RULE7
        !ctrl0_q[0][CTRL0_SYNC_BIT] |=> timer_result[0] == $past(cmp_result_q[0]))
        else $error("async timer path wrong");
    // irq lags the mask register by one cycle, as the mask feeds the next value
    chk_irq_level: assert property (@(posedge clk) disable iff (reset) // see RULE8
        irq == |(cmp_irq_flag_q & $past(irq_mask_q)))
        else $error("irq level wrong");

    cov_rise_irq:  cover property (@(posedge clk) edge_set[0] ##1 irq);
    cov_clear:     cover property (@(posedge clk) flag_clear[0] && cmp_irq_flag_q[0]);
    cov_sync_mode: cover property (@(posedge clk) ctrl0_q[1][CTRL0_SYNC_BIT] && tfall_sync_q[1]);
    cov_set_clear: cover property (@(posedge clk) edge_set[1] && flag_clear[1]);
    cov_pin_drive: cover property (@(posedge clk) pin_oe[0] && pin_out[0]);

endmodule

`default_nettype wire

// file: analog_comparator_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module analog_comparator_control_test;
    import acc_pkg::*;

    logic                  clk;
    logic                  reset;
    logic [3:0]            reg_addr;
    logic [7:0]            reg_wdata;
    logic                  reg_write;
    logic                  reg_read;
    logic [7:0]            reg_rdata;
    logic [1:0]            analog_raw;
    logic                  timer_clk_fall;
    logic [1:0]            pin_direction_bit;
    logic [1:0]            pin_out;
    logic [1:0]            pin_oe;
    logic [1:0]            timer_result;
    acc_analog_cfg_t [1:0] analog_cfg;
    logic                  irq;
    logic [1:0][7:0]       plus_mv;
    logic [3:0][7:0]       minus_mv;
    logic [7:0]            dac_mv;
    logic [7:0]            fixed_mv;
    logic                  timer_run;
    logic                  took_q;
    logic [31:0]           rnd_q;
    logic [7:0]            r;
    logic [7:0]            exp_q[$];
    int                    bad_count;
    int                    tests_run;
    int                    cycles;

    acc_top dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .analog_raw(analog_raw), .timer_clk_fall(timer_clk_fall),
        .pin_direction_bit(pin_direction_bit), .pin_out(pin_out), .pin_oe(pin_oe),
        .timer_result(timer_result), .analog_cfg(analog_cfg), .irq(irq));

    acc_analog_model core (.clk(clk), .cfg(analog_cfg), .plus_mv(plus_mv), .dac_mv(dac_mv),
        .fixed_mv(fixed_mv), .minus_mv(minus_mv), .timer_run(timer_run),
        .raw(analog_raw), .timer_fall(timer_clk_fall));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // expected comparison for comparator 1 under a control1 value
    function automatic logic gt(input logic [7:0] c);
        logic [7:0] vp;
        vp = (c[5:4] == 2'h0) ? plus_mv[0] : (c[5:4] == 2'h1) ? dac_mv :
             (c[5:4] == 2'h2) ? fixed_mv : 8'h00;
        return vp > minus_mv[c[1:0]];
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // strobes are set by every bus task, so back-to-back cycles never drive twice
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        reg_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_write <= 1'b0;
        reg_read <= 1'b1;
        @(posedge clk);
    endtask

    task automatic idle(input int n);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (took_q) check("reg_rdata", reg_rdata, exp_q.pop_front());
        took_q <= reg_read;
    end

    // hang guard, well above the roughly 300 cycles of the run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        {reg_addr, reg_wdata, reg_write, reg_read, pin_direction_bit, timer_run} = '0;
        {took_q, bad_count, tests_run, cycles} = '0;
        reset = 1'b1;
        rnd_q = 32'h5e3ebe93;
        plus_mv = {8'h80, 8'h64};
        minus_mv = {8'hf0, 8'h90, 8'h50, 8'h10};
        dac_mv = 8'hc8;
        fixed_mv = 8'h32;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        idle(2);
        // reset values over the whole map, unmapped places included
        for (int a = 0; a < 16; a++) rd(a[3:0], (a < 2) ? CTRL0_RESET : 8'h00);
        idle(2);
        check("cfg", {1'b0, analog_cfg[0]}, 8'h20);
        check("cfg2", {1'b0, analog_cfg[1]}, 8'h20);
        // every channel pair, random upper bits and random plus level
        wr(ADDR_CTRL0_C1, 8'h86);
        for (int k = 0; k < 16; k++) begin
            rnd_q = xs(rnd_q);
            plus_mv[0] <= rnd_q[15:8];
            r = {rnd_q[7:6], k[1:0], rnd_q[3:2], k[3:2]};
            wr(ADDR_CTRL1_C1, r);
            rd(ADDR_CTRL1_C1, r & 8'hf3);
            idle(6);
            check("cfg", {1'b0, analog_cfg[0]}, {4'h7, r[5:4], r[1:0]});
            rd(ADDR_CTRL0_C1, {1'b1, gt(r), 6'h06});
        end
        plus_mv[0] <= 8'h64;
        wr(ADDR_CTRL1_C1, 8'hc0);
        wr(ADDR_CTRL1_C2, 8'h80);
        wr(ADDR_CTRL0_C1, 8'h04);
        idle(6);
        wr(ADDR_IRQ_STAT, 8'h03);
        wr(ADDR_IRQ_MASK, 8'h01);
        // polarity flip on a disabled comparator gives a rising edge
        wr(ADDR_CTRL0_C1, 8'h14);
        idle(8);
        check("irq", {7'h0, irq}, 8'h01);
        rd(ADDR_IRQ_STAT, 8'h01);
        rd(ADDR_MIRROR, 8'h01);
        rd(ADDR_CTRL0_C1, 8'h54);
        wr(ADDR_IRQ_STAT, 8'h01);
        idle(3);
        check("irq", {7'h0, irq}, 8'h00);
        wr(ADDR_CTRL0_C1, 8'h04);
        idle(8);
        rd(ADDR_IRQ_STAT, 8'h01);
        wr(ADDR_IRQ_STAT, 8'h01);
        // comparator 2 edge while its mask bit is clear
        wr(ADDR_CTRL0_C2, 8'h14);
        // the clear lands in the cycle the new edge is seen, so the flag stays
        idle(1);
        wr(ADDR_IRQ_STAT, 8'h02);
        idle(6);
        check("irq", {7'h0, irq}, 8'h00);
        rd(ADDR_IRQ_STAT, 8'h02);
        rd(ADDR_MIRROR, 8'h02);
        wr(ADDR_IRQ_MASK, 8'h03);
        idle(3);
        check("irq", {7'h0, irq}, 8'h01);
        wr(ADDR_IRQ_STAT, 8'h02);
        wr(ADDR_CTRL0_C2, 8'h04);
        idle(8);
        rd(ADDR_IRQ_STAT, 8'h00);
        // pin routing and direction gating
        wr(ADDR_CTRL0_C1, 8'ha4);
        idle(8);
        check("pin", {2'h0, pin_oe, pin_out, timer_result}, 8'h15);
        pin_direction_bit <= 2'b01;
        idle(3);
        check("pin_oe", {7'h0, pin_oe[0]}, 8'h00);
        // sync mode holds the timer path between timer clock falls
        wr(ADDR_CTRL0_C1, 8'ha5);
        timer_run <= 1'b1;
        idle(14);
        check("timer", {7'h0, timer_result[0]}, 8'h01);
        timer_run <= 1'b0;
        plus_mv[0] <= 8'h00;
        idle(8);
        rd(ADDR_CTRL0_C1, 8'ha5);
        idle(2);
        check("timer", {7'h0, timer_result[0]}, 8'h01);
        timer_run <= 1'b1;
        idle(14);
        check("timer", {7'h0, timer_result[0]}, 8'h00);
        idle(3);
        summarize();
    end
endmodule

`default_nettype wire
